// ===== rtl/felc_ctrl.sv
// flash controller: unlock sequence, erase and program sequencing, option decode
`timescale 1ns/10ps
module felc_ctrl
  import felc_pkg::*;
#(
  parameter logic [DUR_W-1:0] PROG_TIME_US   = 18'h00028,
  parameter logic [DUR_W-1:0] PERASE_TIME_US = 18'h02710,
  parameter logic [DUR_W-1:0] MERASE_TIME_US = 18'h30d40
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register file port
  input  wire logic [11:0]       reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // cpu program writes
  input  wire logic              cpu_prog_valid,
  input  wire logic [ADDR_W-1:0] cpu_prog_addr,
  input  wire logic [7:0]        cpu_prog_data,
  output logic                   cpu_prog_ready,
  // flash array side
  input  wire logic [7:0]        opt_byte,
  output felc_arr_cmd_t          arr_cmd,
  // watchdog
  input  wire logic              wdt_timeout,
  input  wire logic              wdt_start_insn,
  input  wire logic              stop_recovery,
  output logic                   wdt_short_reset,
  output logic                   wdt_irq,
  output logic                   wdt_run,
  // debugger and option outputs
  output logic                   dbg_code_read_en,
  output felc_opt_t              opt_q
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  felc_lock_t        lock_q;
  felc_op_t          op_q;
  felc_arr_cmd_t     arr_q;
  logic              opt_loaded_q;
  logic [PAGE_W-1:0] page_q;
  logic [7:0]        freq_hi_q;
  logic [7:0]        freq_lo_q;
  logic [7:0]        rdata_q;
  logic              reject_q;
  logic              wdt_run_q;
  logic              wdt_rst_q;
  logic              wdt_irq_q;
  logic              dbg_en_q;
  logic              idle;
  logic              cmd_wr;
  logic              pe_cmd;
  logic              me_cmd;
  logic              prog_take;
  logic              start_prog;
  logic              start_pe;
  logic              start_me;
  logic              refused;
  logic              tmr_done;
  logic [DUR_W-1:0]  dur_sel;
  logic [ADDR_W-1:0] page_addr;
  logic [7:0]        status;

  // a write is refused where the option bits protect its target
  function automatic logic addr_blocked(input logic [ADDR_W-1:0] a, input felc_opt_t o);
    return !o.array_protect_option || ((a >= HS_BASE) && !o.high_sector_protect_option);
  endfunction

  // ----------------------------------------------------------------
  // option byte capture
  // ----------------------------------------------------------------
  // defaults until loaded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_loaded_q <= 1'b0;
    end else begin
      opt_loaded_q <= 1'b1;
    end
  end

  // option bits sampled
  // reloaded only after reset, so reprogramming takes effect next reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_q <= felc_opt_t'(OPT_ERASED);
    end else if (!opt_loaded_q) begin
      opt_q <= felc_opt_t'(opt_byte);
    end
  end

  // ----------------------------------------------------------------
  // decode of register writes
  // ----------------------------------------------------------------
  assign idle       = (op_q == OP_IDLE);
  assign cmd_wr     = reg_wr_en && (reg_addr == REG_CMD_OFS) && idle;
  assign page_addr  = {page_q, {PAGE_SHIFT{1'b0}}};
  assign pe_cmd     = cmd_wr && (lock_q == LK_OPEN) && (reg_wdata == CMD_PAGE_ERS);
  assign me_cmd     = cmd_wr && (lock_q == LK_OPEN) && (reg_wdata == CMD_MASS_ERS);
  assign start_pe   = pe_cmd && !addr_blocked(page_addr, opt_q);
  assign start_me   = me_cmd && opt_q.array_protect_option && opt_q.high_sector_protect_option;
  assign prog_take  = cpu_prog_valid && cpu_prog_ready;
  assign start_prog = prog_take && (lock_q == LK_OPEN) && !addr_blocked(cpu_prog_addr, opt_q);
  assign refused    = (pe_cmd && !start_pe) || (me_cmd && !start_me) ||
                      (prog_take && !start_prog);
  assign cpu_prog_ready = idle && !pe_cmd && !me_cmd;

  // ----------------------------------------------------------------
  // lock sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= LK_LOCKED;
    end else if (cmd_wr) begin
      unique case (lock_q)
        LK_LOCKED: lock_q <= (reg_wdata == CMD_UNLOCK1) ? LK_FIRST : LK_LOCKED;
        LK_FIRST:  lock_q <= (reg_wdata == CMD_UNLOCK2) ? LK_OPEN : LK_LOCKED;
        // third command consumes the unlock, valid or not
        LK_OPEN:   lock_q <= LK_LOCKED;
        default:   lock_q <= LK_LOCKED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // user registers
  // ----------------------------------------------------------------
  // frequency bytes
  // held while busy so the running pulse keeps its length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_hi_q <= FREQ_RESET;
      freq_lo_q <= FREQ_RESET;
      page_q    <= '0;
    end else if (reg_wr_en && idle) begin
      if (reg_addr == REG_FREQH_OFS) begin
        freq_hi_q <= reg_wdata;
      end
      if (reg_addr == REG_FREQL_OFS) begin
        freq_lo_q <= reg_wdata;
      end
      if (reg_addr == REG_PAGE_OFS) begin
        page_q <= reg_wdata[PAGE_W-1:0];
      end
    end
  end

  // sticky refusal flag; a new refusal beats the read that clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reject_q <= 1'b0;
    end else if (refused) begin
      reject_q <= 1'b1;
    end else if (reg_rd_en && (reg_addr == REG_CMD_OFS)) begin
      reject_q <= 1'b0;
    end
  end

  always_comb begin
    status            = READ_ZERO;
    status[ST_FIRST]  = (lock_q == LK_FIRST);
    status[ST_OPEN]   = (lock_q == LK_OPEN);
    status[ST_BUSY]   = !idle;
    status[ST_ERASE]  = (op_q == OP_PERASE) || (op_q == OP_MERASE);
    status[ST_REJECT] = reject_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= READ_ZERO;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        REG_CMD_OFS:   rdata_q <= status;
        REG_PAGE_OFS:  rdata_q <= 8'(page_q);
        REG_FREQH_OFS: rdata_q <= freq_hi_q;
        REG_FREQL_OFS: rdata_q <= freq_lo_q;
        default:       rdata_q <= READ_ZERO;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  assign dur_sel = start_me ? MERASE_TIME_US : (start_pe ? PERASE_TIME_US : PROG_TIME_US);

  felc_timer u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (start_prog || start_pe || start_me),
    .khz    ({freq_hi_q, freq_lo_q}),
    .dur_us (dur_sel),
    .busy   (),
    .done   (tmr_done)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= OP_IDLE;
    end else begin
      unique case (op_q)
        OP_IDLE: begin
          if (start_prog) begin
            op_q <= OP_PROG;
          end else if (start_pe) begin
            op_q <= OP_PERASE;
          end else if (start_me) begin
            op_q <= OP_MERASE;
          end
        end
        OP_PROG, OP_PERASE, OP_MERASE: begin
          if (tmr_done) begin
            op_q <= OP_IDLE;
          end
        end
        default: op_q <= OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_q <= '0;
    end else if (start_prog) begin
      arr_q.prog  <= 1'b1;
      arr_q.addr  <= cpu_prog_addr;
      arr_q.row   <= cpu_prog_addr[PAGE_SHIFT-1:ROW_SHIFT];
      arr_q.wdata <= cpu_prog_data;
    end else if (start_pe) begin
      arr_q.page_erase <= 1'b1;
      arr_q.addr       <= page_addr;
      arr_q.row        <= '0;
    end else if (start_me) begin
      arr_q.mass_erase <= 1'b1;
      arr_q.addr       <= OPT_ADDR;
      arr_q.row        <= '0;
    end else if (tmr_done) begin
      arr_q.prog       <= 1'b0;
      arr_q.page_erase <= 1'b0;
      arr_q.mass_erase <= 1'b0;
    end
  end

  assign arr_cmd = arr_q;

  // ----------------------------------------------------------------
  // watchdog and debugger options
  // ----------------------------------------------------------------
  // always-on or instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_run_q <= 1'b0;
    end else if (!opt_q.watchdog_always_on) begin
      wdt_run_q <= 1'b1;
    end else if (stop_recovery) begin
      wdt_run_q <= 1'b0;
    end else if (wdt_start_insn) begin
      wdt_run_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_rst_q <= 1'b0;
      wdt_irq_q <= 1'b0;
    end else begin
      wdt_rst_q <= wdt_timeout && opt_q.watchdog_timeout_action;
      wdt_irq_q <= wdt_timeout && !opt_q.watchdog_timeout_action;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_en_q <= 1'b0;
    end else begin
      dbg_en_q <= opt_loaded_q && opt_q.read_protect_option;
    end
  end

  assign wdt_run          = wdt_run_q;
  assign wdt_short_reset  = wdt_rst_q;
  assign wdt_irq          = wdt_irq_q;
  assign dbg_code_read_en = dbg_en_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // second code opens
  unlock_second_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_wr && lock_q == LK_FIRST && reg_wdata == CMD_UNLOCK2) |=> lock_q == LK_OPEN)
    else $error("second unlock code did not open");

  unlock_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lock_q == LK_OPEN && $past(lock_q) != LK_OPEN) |->
      ($past(cmd_wr) && $past(reg_wdata) == CMD_UNLOCK2 && $past(lock_q) == LK_FIRST))
    else $error("opened without unlock pair");

  bad_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_wr && lock_q != LK_LOCKED && !pe_cmd && !me_cmd &&
     !(lock_q == LK_FIRST && reg_wdata == CMD_UNLOCK2)) |=> lock_q == LK_LOCKED)
    else $error("unexpected command did not relock");

  page_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_pe |=> (op_q == OP_PERASE) && arr_cmd.page_erase && arr_cmd.addr == $past(page_addr))
    else $error("page erase did not start");

  mass_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_me |=> (op_q == OP_MERASE) && arr_cmd.mass_erase && !arr_cmd.page_erase)
    else $error("mass erase did not start");

  locked_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (idle && lock_q != LK_OPEN) |=> idle)
    else $error("operation started while locked");

  page_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    arr_cmd.page_erase |-> arr_cmd.addr[PAGE_SHIFT-1:0] == '0)
    else $error("page erase address not page aligned");

  sector_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    (arr_cmd.prog && arr_cmd.addr >= HS_BASE) |-> opt_q.high_sector_protect_option)
    else $error("protected high sector programmed");

  wdt_action_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_timeout |=> (wdt_short_reset == $past(opt_q.watchdog_timeout_action)) &&
                    (wdt_irq != wdt_short_reset))
    else $error("watchdog timeout action wrong");

  wdt_always_a: assert property (@(posedge clk) disable iff (!rst_n)
    (opt_loaded_q && !opt_q.watchdog_always_on) |=> ##1 wdt_run)
    else $error("always-on watchdog not running");

  dbg_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    opt_loaded_q |=> dbg_code_read_en == $past(opt_q.read_protect_option))
    else $error("debugger read gate wrong");

  page_erase_c: cover property (@(posedge clk) disable iff (!rst_n) start_pe ##[1:300] tmr_done);
  mass_erase_c: cover property (@(posedge clk) disable iff (!rst_n) start_me);
  prog_byte_c:  cover property (@(posedge clk) disable iff (!rst_n) start_prog);
  relock_c:     cover property (@(posedge clk) disable iff (!rst_n)
    (lock_q == LK_FIRST) ##1 (lock_q == LK_LOCKED));

endmodule // felc_ctrl

// ===== rtl/felc_timer.sv
// pulse timer scaling a duration in microseconds by the kHz clock value
`timescale 1ns/10ps
module felc_timer
  import felc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             start,
  input  wire logic [15:0]      khz,
  input  wire logic [DUR_W-1:0] dur_us,
  // status
  output logic                  busy,
  output logic                  done
);

  // ----------------------------------------------------------------
  // cycle count from time
  // ----------------------------------------------------------------
  logic [33:0]      prod;
  logic [33:0]      cyc;
  logic [CYC_W-1:0] target;
  logic [CYC_W-1:0] cnt_q;

  assign prod   = 34'(khz) * 34'(dur_us);
  // least time, so round up; never below one cycle
  assign cyc    = (prod + CYC_ROUND) / US_PER_MS;
  assign target = (cyc[CYC_W-1:0] == '0) ? MIN_CYC : cyc[CYC_W-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= target;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - MIN_CYC;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= (cnt_q == MIN_CYC) && !start;
    end
  end

  assign busy = (cnt_q != '0);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // count then done
  timer_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && cnt_q == MIN_CYC && !start) |=> done && !busy)
    else $error("timer did not finish after last count");

endmodule // felc_timer

// ===== shared/felc_pkg.sv
// constants, types and state codes of the flash erase and lock controller
package felc_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int unsigned     ADDR_W        = 16;
  localparam logic [16:0]     ARRAY_BYTES   = 17'h10000;
  localparam int unsigned     PAGE_SHIFT    = 9;
  localparam int unsigned     ROW_SHIFT     = 6;
  localparam int unsigned     PAGE_W        = ADDR_W - PAGE_SHIFT;
  localparam int unsigned     ROW_W         = PAGE_SHIFT - ROW_SHIFT;
  localparam logic [15:0]     HS_BASE       = 16'he000;
  localparam logic [15:0]     OPT_ADDR      = 16'h0000;
  localparam logic [15:0]     OPT_LAST_ADDR = 16'h0001;

  // ----------------------------------------------------------------
  // register file offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0]     REG_CMD_OFS   = 12'hff8;
  localparam logic [11:0]     REG_PAGE_OFS  = 12'hff9;
  localparam logic [11:0]     REG_FREQH_OFS = 12'hffa;
  localparam logic [11:0]     REG_FREQL_OFS = 12'hffb;
  localparam logic [7:0]      CMD_RESET     = 8'h00;
  localparam logic [7:0]      FREQ_RESET    = 8'h00;
  localparam logic [7:0]      READ_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0]      CMD_UNLOCK1   = 8'h73;
  localparam logic [7:0]      CMD_UNLOCK2   = 8'h8c;
  localparam logic [7:0]      CMD_PAGE_ERS  = 8'h95;
  localparam logic [7:0]      CMD_MASS_ERS  = 8'h63;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned     ST_FIRST      = 0;
  localparam int unsigned     ST_OPEN       = 1;
  localparam int unsigned     ST_BUSY       = 2;
  localparam int unsigned     ST_ERASE      = 3;
  localparam int unsigned     ST_REJECT     = 4;

  // ----------------------------------------------------------------
  // option byte and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]      OPT_ERASED    = 8'hff;
  localparam int unsigned     DUR_W         = 18;
  localparam int unsigned     CYC_W         = 26;
  localparam logic [33:0]     US_PER_MS     = 34'h00000003e8;
  localparam logic [33:0]     CYC_ROUND     = 34'h00000003e7;
  localparam logic [CYC_W-1:0] MIN_CYC      = 26'h0000001;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,
    LK_FIRST  = 3'b010,
    LK_OPEN   = 3'b100
  } felc_lock_t;

  typedef enum logic [3:0] {
    OP_IDLE   = 4'b0001,
    OP_PROG   = 4'b0010,
    OP_PERASE = 4'b0100,
    OP_MERASE = 4'b1000
  } felc_op_t;

  typedef struct packed {
    logic       watchdog_timeout_action;
    logic       watchdog_always_on;
    logic [2:0] rsvd;
    logic       read_protect_option;
    logic       high_sector_protect_option;
    logic       array_protect_option;
  } felc_opt_t;

  typedef struct packed {
    logic              prog;
    logic              page_erase;
    logic              mass_erase;
    logic [ROW_W-1:0]  row;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } felc_arr_cmd_t;

endpackage

// ===== tb/felc_flash_model.sv
// flash array model: supplies the option byte and records array operations
`timescale 1ns/10ps
module felc_flash_model
  import felc_pkg::*;
#(
  parameter logic [7:0] OPT_VAL = 8'hff
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // controller side
  input  wire felc_arr_cmd_t arr_cmd,
  output logic [7:0]         opt_byte,
  // observed operations
  output int                 n_prog,
  output int                 n_perase,
  output int                 n_merase,
  output logic [15:0]        last_addr
);
  logic [2:0] prev_q;

  // option byte at address zero
  // survives reset, so it is driven as a constant
  assign opt_byte = OPT_VAL;

  // count each operation once, on its rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q    <= 3'h0;
      n_prog    <= 0;
      n_perase  <= 0;
      n_merase  <= 0;
      last_addr <= 16'hffff;
    end else begin
      prev_q <= {arr_cmd.prog, arr_cmd.page_erase, arr_cmd.mass_erase};
      if (arr_cmd.prog && !prev_q[2]) begin
        n_prog    <= n_prog + 1;
        last_addr <= arr_cmd.addr;
      end
      if (arr_cmd.page_erase && !prev_q[1]) begin
        n_perase  <= n_perase + 1;
        last_addr <= arr_cmd.addr;
      end
      if (arr_cmd.mass_erase && !prev_q[0]) begin
        n_merase  <= n_merase + 1;
        last_addr <= arr_cmd.addr;
      end
    end
  end

endmodule // felc_flash_model

// ===== tb/tb.sv
// self-checking bench of the flash erase and lock controller
`timescale 1ns/10ps
module tb;
  import felc_pkg::*;
  logic          clk, rst_n, wr, rd, pv, wsi, wto, srec;
  logic [11:0]   ra;
  logic [7:0]    wd, pd, rdata, opt_byte, s;
  logic [15:0]   pa, last_addr;
  logic          ready, wsr, wirq, wrun, dbg;
  felc_arr_cmd_t arr_cmd;
  felc_opt_t     opt_q;
  int            n_prog, n_perase, n_merase, err_count, num_checks, cyc;
  logic [7:0]    opt_byte2;
  logic          wirq2, wrun2, dbg2;
  felc_arr_cmd_t arr2;
  felc_opt_t     opt2;
  int            p2, e2, m2;

  felc_ctrl #(.PROG_TIME_US(18'h00002), .PERASE_TIME_US(18'h00005),
    .MERASE_TIME_US(18'h00008)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(ra),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_wdata(wd), .reg_rdata(rdata),
    .cpu_prog_valid(pv), .cpu_prog_addr(pa), .cpu_prog_data(pd),
    .cpu_prog_ready(ready), .opt_byte(opt_byte), .arr_cmd(arr_cmd),
    .wdt_timeout(wto), .wdt_start_insn(wsi), .stop_recovery(srec),
    .wdt_short_reset(wsr), .wdt_irq(wirq), .wdt_run(wrun),
    .dbg_code_read_en(dbg), .opt_q(opt_q));

  felc_flash_model model (.clk(clk), .rst_n(rst_n), .arr_cmd(arr_cmd),
    .opt_byte(opt_byte), .n_prog(n_prog), .n_perase(n_perase),
    .n_merase(n_merase), .last_addr(last_addr));

  // guarded copy: every option cleared but the reserved bits
  felc_ctrl #(.PROG_TIME_US(18'h00002), .PERASE_TIME_US(18'h00005),
    .MERASE_TIME_US(18'h00008)) dut2 (.clk(clk), .rst_n(rst_n), .reg_addr(ra),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_wdata(wd), .reg_rdata(),
    .cpu_prog_valid(pv), .cpu_prog_addr(pa), .cpu_prog_data(pd),
    .cpu_prog_ready(), .opt_byte(opt_byte2), .arr_cmd(arr2),
    .wdt_timeout(wto), .wdt_start_insn(wsi), .stop_recovery(srec),
    .wdt_short_reset(), .wdt_irq(wirq2), .wdt_run(wrun2),
    .dbg_code_read_en(dbg2), .opt_q(opt2));

  felc_flash_model #(.OPT_VAL(8'h38)) model2 (.clk(clk), .rst_n(rst_n), .arr_cmd(arr2),
    .opt_byte(opt_byte2), .n_prog(p2), .n_perase(e2), .n_merase(m2), .last_addr());

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // back to back calls keep the strobe high: consecutive writes
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr = 1'b1;
    ra = a;
    wd = d;
  endtask

  task automatic idle(input int n);
    @(posedge clk);
    #1;
    wr = 1'b0;
    pv = 1'b0;
    wsi = 1'b0;
    wto = 1'b0;
    srec = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b1;
    ra = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic prog(input logic [15:0] a);
    @(posedge clk);
    #1;
    pv = 1'b1;
    pa = a;
    pd = 8'h5a;
    idle(20);
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run needs under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  initial begin
    {rst_n, wr, rd, pv, wsi, wto, srec} = 7'h00;
    {ra, wd, pd, pa} = 44'h0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle(3);
    chk("option latch", 16'h00ff, {8'h00, opt_q});
    chk("debug read", 16'h0001, {15'h0, dbg});
    chk("watchdog idle", 16'h0000, {15'h0, wrun});
    chk("guarded options", 16'h0038, {8'h00, opt2});
    chk("guarded debug", 16'h0000, {15'h0, dbg2});
    chk("always-on watchdog", 16'h0001, {15'h0, wrun2});
    rd_reg(12'h100, s);
    chk("unmapped read", 16'h0000, {8'h00, s});
    // locked program write must not reach the array
    prog(16'h1234);
    chk("locked prog", 16'h0000, n_prog[15:0]);
    rd_reg(REG_CMD_OFS, s);
    chk("refusal flag", 16'h0010, {8'h00, s & 8'h10});
    // page erase of page five at 50 kHz
    wr_reg(REG_PAGE_OFS, 8'h05);
    wr_reg(REG_FREQH_OFS, 8'h00);
    wr_reg(REG_FREQL_OFS, 8'h32);
    wr_reg(REG_CMD_OFS, CMD_UNLOCK1);
    wr_reg(REG_CMD_OFS, CMD_UNLOCK2);
    rd_reg(REG_CMD_OFS, s);
    chk("unlocked status", 16'h0002, {8'h00, s & 8'h06});
    wr_reg(REG_CMD_OFS, CMD_PAGE_ERS);
    // busy and erasing while the pulse runs, relocked by the third command
    rd_reg(REG_CMD_OFS, s);
    chk("erase status", 16'h000c, {8'h00, s & 8'h0e});
    chk("ready while busy", 16'h0000, {15'h0, ready});
    idle(20);
    chk("page erases", 16'h0001, n_perase[15:0]);
    chk("page base", 16'h0a00, last_addr);
    // broken sequence relocks, later codes do nothing
    wr_reg(REG_CMD_OFS, CMD_UNLOCK1);
    wr_reg(REG_CMD_OFS, 8'h12);
    wr_reg(REG_CMD_OFS, CMD_UNLOCK2);
    wr_reg(REG_CMD_OFS, CMD_PAGE_ERS);
    idle(20);
    chk("relocked", 16'h0001, n_perase[15:0]);
    // mass erase
    wr_reg(REG_CMD_OFS, CMD_UNLOCK1);
    wr_reg(REG_CMD_OFS, CMD_UNLOCK2);
    wr_reg(REG_CMD_OFS, CMD_MASS_ERS);
    idle(20);
    chk("mass erases", 16'h0001, n_merase[15:0]);
    chk("mass addr", 16'h0000, last_addr);
    // unlocked program write
    wr_reg(REG_CMD_OFS, CMD_UNLOCK1);
    wr_reg(REG_CMD_OFS, CMD_UNLOCK2);
    idle(1);
    prog(16'h13c0);
    chk("prog count", 16'h0001, n_prog[15:0]);
    chk("prog addr", 16'h13c0, last_addr);
    chk("prog row", 16'h0007, {13'h0, arr_cmd.row});
    chk("prog data", 16'h005a, {8'h00, arr_cmd.wdata});
    // top sector open with erased options; program does not relock
    prog(16'hf000);
    chk("high sector prog", 16'h0002, n_prog[15:0]);
    chk("high sector addr", 16'hf000, last_addr);
    // watchdog started by its instruction
    @(posedge clk);
    #1;
    wsi = 1'b1;
    idle(2);
    chk("watchdog run", 16'h0001, {15'h0, wrun});
    @(posedge clk);
    #1;
    wto = 1'b1;
    idle(0);
    chk("timeout reset", 16'h0001, {15'h0, wsr});
    chk("timeout irq", 16'h0000, {15'h0, wirq});
    chk("guarded irq", 16'h0001, {15'h0, wirq2});
    @(posedge clk);
    #1;
    srec = 1'b1;
    idle(0);
    chk("watchdog stopped", 16'h0000, {15'h0, wrun});
    chk("always-on kept", 16'h0001, {15'h0, wrun2});
    chk("guarded ops", 16'h0000, 16'(p2 + e2 + m2));
    results();
  end
endmodule // tb
